// ==== rtl/lvp_defines.svh ====
// constants for the low-voltage converter and board power control block
`ifndef LVP_DEFINES_SVH
`define LVP_DEFINES_SVH

// command codes
`define LVP_CODE_CTRL_BYTE   16'h8000
`define LVP_CODE_RESULT      16'h8004
`define LVP_CODE_POWER_EN    16'h8010
`define LVP_CODE_POWER_STATE 16'h8018
`define LVP_CODE_SELECT      16'h8020
`define LVP_CODE_SELECT_RB   16'h8024

// control byte field positions
`define LVP_CB_START      7
`define LVP_CB_CHAN_MSB   6
`define LVP_CB_CHAN_LSB   4
`define LVP_CB_RANGE      3
`define LVP_CB_BIPOLAR    2
`define LVP_CB_PMODE_MSB  1
`define LVP_CB_PMODE_LSB  0

// power mask layout
`define LVP_PWR_TRIGGER_BIT 7

// widths and reset values
`define LVP_NUM_CONV      7
`define LVP_CTRL_BITS     8
`define LVP_RESULT_BITS   16
`define LVP_POWER_RESET   8'h00
`define LVP_SELECT_RESET  3'h0

// timing
`define LVP_CLK_NS        4
`define LVP_SCLK_HALF_NS  20
`define LVP_CONV_NS       4000
`define LVP_SCLK_HALF_CYC ((`LVP_SCLK_HALF_NS + `LVP_CLK_NS - 1) / `LVP_CLK_NS)
`define LVP_CONV_CYC      ((`LVP_CONV_NS + `LVP_CLK_NS - 1) / `LVP_CLK_NS)

`endif

// ==== rtl/lvp_pkg.sv ====
// types shared by the converter control block
package lvp_pkg;

  // serial engine sequence, one-hot
  typedef enum logic [3:0]
  {
    LVP_IDLE = 4'b0001,
    LVP_SEND = 4'b0010,
    LVP_CONV = 4'b0100,
    LVP_RECV = 4'b1000
  } lvp_seq_e;

  typedef logic [15:0] lvp_word_t;

endpackage

// ==== rtl/lvp_serial_if.sv ====
// link between the command decoder and the converter serial engine
`timescale 1ns/10ps
interface lvp_serial_if;
  logic        start;    // one-cycle request to send a control byte
  logic [7:0]  ctrlByte; // byte to send, held with start
  logic        busy;     // engine running a transfer
  logic        done;     // one-cycle pulse, result valid
  logic [15:0] result;   // word shifted back from the converter
  logic        sclk;     // serial clock to the converters
  logic        din;      // serial data to the converters
  logic        sdo;      // synchronised serial data from the selected converter

  modport ctrl (output start, output ctrlByte, output sdo,
                input busy, input done, input result, input sclk, input din);
  modport engine (input start, input ctrlByte, input sdo,
                  output busy, output done, output result, output sclk, output din);
endinterface

// ==== rtl/lvp_adc_serial.sv ====
// serial engine: sends the control byte and shifts back the conversion word
`timescale 1ns/10ps
`include "lvp_defines.svh"
module lvp_adc_serial
#(
  parameter int HALF_CYC = `LVP_SCLK_HALF_CYC,
  parameter int CONV_CYC = `LVP_CONV_CYC
)
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  lvp_serial_if.engine link
);
  import lvp_pkg::*;

  lvp_seq_e    seq;        // sequence state
  logic [15:0] phaseCnt;   // cycles within a half serial clock
  logic [4:0]  bitCnt;     // bits done in this phase
  logic [15:0] convCnt;    // conversion wait
  logic        sclkQ;      // serial clock flop
  logic        halfTick;   // half period elapsed
  logic        riseEdge;   // serial clock about to rise
  logic        fallEdge;   // serial clock about to fall
  logic [7:0]  shiftOut;   // outgoing control byte
  logic [15:0] shiftIn;    // incoming result

  // edge strobes, only while clocking
  always_comb
  begin
    halfTick = (seq == LVP_SEND || seq == LVP_RECV) && (phaseCnt == 16'(HALF_CYC - 1));
    riseEdge = halfTick && !sclkQ;
    fallEdge = halfTick && sclkQ;
  end

  // sequencer and serial clock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq      <= LVP_IDLE;
      phaseCnt <= 16'h0000;
      bitCnt   <= 5'h00;
      convCnt  <= 16'h0000;
      sclkQ    <= 1'b0;
    end
    else
    begin
      unique case (seq)
        LVP_IDLE:
        begin
          phaseCnt <= 16'h0000;
          bitCnt   <= 5'h00;
          sclkQ    <= 1'b0;
          if (link.start)
            seq <= LVP_SEND;
        end
        LVP_SEND:
        begin
          phaseCnt <= halfTick ? 16'h0000 : phaseCnt + 16'h0001;
          if (halfTick)
            sclkQ <= ~sclkQ;
          if (fallEdge)
          begin
            // last falling edge of the byte ends the send phase
            if (bitCnt == 5'(`LVP_CTRL_BITS - 1))
            begin
              seq     <= LVP_CONV;
              bitCnt  <= 5'h00;
              convCnt <= 16'h0000;
            end
            else
              bitCnt <= bitCnt + 5'h01;
          end
        end
        LVP_CONV:
        begin
          // wait out the conversion with the serial clock low
          convCnt <= convCnt + 16'h0001;
          if (convCnt == 16'(CONV_CYC - 1))
          begin
            seq      <= LVP_RECV;
            phaseCnt <= 16'h0000;
          end
        end
        LVP_RECV:
        begin
          phaseCnt <= halfTick ? 16'h0000 : phaseCnt + 16'h0001;
          if (halfTick)
            sclkQ <= ~sclkQ;
          if (fallEdge)
          begin
            if (bitCnt == 5'(`LVP_RESULT_BITS - 1))
              seq <= LVP_IDLE;
            else
              bitCnt <= bitCnt + 5'h01;
          end
        end
      endcase
    end
  end

  // shift registers, data line and result
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftOut    <= 8'h00;
      shiftIn     <= 16'h0000;
      link.din    <= 1'b0;
      link.result <= 16'h0000;
      link.done   <= 1'b0;
    end
    else
    begin
      link.done <= 1'b0;
      if (seq == LVP_IDLE && link.start)
      begin
        // msb first, first bit presented before the first rising edge
        shiftOut <= {link.ctrlByte[6:0], 1'b0};
        link.din <= link.ctrlByte[7];
      end
      else if (seq == LVP_SEND && fallEdge)
      begin
        link.din <= shiftOut[7];
        shiftOut <= {shiftOut[6:0], 1'b0};
      end
      else if (seq == LVP_CONV)
        link.din <= 1'b0;
      // sample on rising edge of the serial clock
      if (seq == LVP_RECV && riseEdge)
        shiftIn <= {shiftIn[14:0], link.sdo};
      if (seq == LVP_RECV && fallEdge && bitCnt == 5'(`LVP_RESULT_BITS - 1))
      begin
        link.result <= shiftIn;
        link.done   <= 1'b1;
      end
    end
  end

  assign link.sclk = sclkQ;
  assign link.busy = (seq != LVP_IDLE);

endmodule

// ==== rtl/lvp_adc_power_control.sv ====
// command-decoded converter control and board power switching
`timescale 1ns/10ps
`include "lvp_defines.svh"
// Contract
// - write 8000 sends control byte to converter
// - write 8010 loads board power mask
// - read 8018 returns board power state
// - write 8020 selects converter zero to six
// - read 8024 returns selected converter index
module lvp_adc_power_control
#(
  parameter int NUM_CONV = `LVP_NUM_CONV,
  parameter int HALF_CYC = `LVP_SCLK_HALF_CYC,
  parameter int CONV_CYC = `LVP_CONV_CYC
)
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // host command bus
  input  wire logic              cmdStrobe,
  input  wire logic              cmdWrite,
  input  wire logic [15:0]       cmdCode,
  input  wire lvp_pkg::lvp_word_t cmdWdata,
  output logic                   cmdAck,
  output lvp_pkg::lvp_word_t     cmdRdata,
  // converter serial link
  output logic                   adcSclk,
  output logic                   adcDin,
  output logic [NUM_CONV-1:0]    adcCs_n,
  input  wire logic [NUM_CONV-1:0] adcDout,
  // board supply switches
  output logic [7:0]             boardPowerOn
);
  import lvp_pkg::*;

  // request, status and serial lines shared with the engine
  lvp_serial_if link ();

  // registers the host writes and reads back
  logic [7:0]          powerMask;              // board supply enables
  logic [2:0]          convSelect;             // converter addressed by sends and reads

  // converter data path
  logic [2:0]          activeSel;              // converter of the transfer in flight
  logic [NUM_CONV-1:0] doutMeta;               // first synchroniser stage
  logic [NUM_CONV-1:0] doutSync;               // second synchroniser stage
  lvp_word_t           results [NUM_CONV];     // last result per converter

  // command decode helpers
  logic                isWrite;                // write strobe this cycle
  logic                isRead;                 // read strobe this cycle
  logic                sendReq;                // control byte accepted
  lvp_word_t           next_rdata;             // read mux

  // one strobe per command, split by direction
  assign isWrite = cmdStrobe && cmdWrite;
  assign isRead  = cmdStrobe && !cmdWrite;
  // a send while a transfer is running is dropped; the host still gets its
  // ack and must wait for the select lines to go high before sending again
  assign sendReq = isWrite && (cmdCode == `LVP_CODE_CTRL_BYTE) && !link.busy;

  // two-flop synchroniser on the converter data pins; the pins move on the
  // converters' own timing, so only the second stage feeds the engine mux
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      doutMeta <= '0;
      doutSync <= '0;
    end
    else
    begin
      // shift the pins through both stages
      doutMeta <= adcDout;
      doutSync <= doutMeta;
    end
  end

  // power mask register: bit 7 switches the trigger board supply, bits 6 to 0
  // the front-end boards; writes to any other code leave the supplies alone
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      powerMask <= `LVP_POWER_RESET;
    else if (isWrite && cmdCode == `LVP_CODE_POWER_EN)
      powerMask <= cmdWdata[7:0];
  end

  // converter select register; the host keeps to 0 to 6, a stored 7 is read
  // back as written but addresses no converter
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      convSelect <= `LVP_SELECT_RESET;
    else if (isWrite && cmdCode == `LVP_CODE_SELECT)
      convSelect <= cmdWdata[2:0];
  end

  // latch the target when a send starts so a reselect cannot split a transfer;
  // the result store and the data mux both follow this copy
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      activeSel <= `LVP_SELECT_RESET;
    else if (sendReq)
      activeSel <= convSelect;
  end

  // per-converter result store; each slot keeps its last word until the next
  // transfer to the same converter, so reselecting shows an older result
  // one slot per converter
  generate
    for (genvar i = 0; i < NUM_CONV; i++)
    begin : gResult
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          results[i] <= 16'h0000;
        // store the finished word in the slot of its converter
        else if (link.done && activeSel == 3'(i))
          results[i] <= link.result;
      end
    end
  endgenerate

  // chip select follows the latched target only while the engine runs; it
  // rises one cycle after the last falling serial clock edge
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      adcCs_n <= '1;
    else
    begin
      for (int i = 0; i < NUM_CONV; i++)
      begin
        // new transfer: only the chosen line goes low
        if (sendReq)
          adcCs_n[i] <= !(convSelect == 3'(i));
        // engine idle again: release every line
        else if (!link.busy)
          adcCs_n[i] <= 1'b1;
      end
    end
  end

  // request to the serial engine and data from the chosen converter; the
  // control byte is forwarded as the host formatted it, no field is checked
  always_comb
  begin
    // start and byte go out in the accept cycle
    link.start    = sendReq;
    link.ctrlByte = cmdWdata[7:0];
    link.sdo      = 1'b0;
    for (int i = 0; i < NUM_CONV; i++)
    begin
      if (activeSel == 3'(i))
        link.sdo = doutSync[i];
    end
  end

  // serial engine; the data in is sampled two cycles late through the
  // synchroniser, so a half serial clock shorter than three cycles would
  // take each result bit from the previous bit time
  lvp_adc_serial #(
    .HALF_CYC (HALF_CYC),
    .CONV_CYC (CONV_CYC)
  ) uSerial (
    .mclk  (mclk),
    .rst_n (rst_n),
    .link  (link)
  );

  // read data mux, unmapped codes read as zero; the write-only codes fall
  // into the default branch as well
  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (cmdCode)
      `LVP_CODE_RESULT:
      begin
        // select above range reads zero
        for (int i = 0; i < NUM_CONV; i++)
        begin
          if (convSelect == 3'(i))
            next_rdata = results[i];
        end
      end
      // power state reads back the mask
      `LVP_CODE_POWER_STATE: next_rdata = {8'h00, powerMask};
      // selected index, zero-extended
      `LVP_CODE_SELECT_RB:   next_rdata = {13'h0, convSelect};
      default:               next_rdata = 16'h0000;
    endcase
  end

  // answer one cycle after every strobe, mapped or not; read data is only
  // refreshed on reads so it holds until the next read
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // quiet bus out of reset
      cmdAck   <= 1'b0;
      cmdRdata <= 16'h0000;
    end
    else
    begin
      // one ack pulse per strobe
      cmdAck <= cmdStrobe;
      // reads alone refresh the data
      if (isRead)
        cmdRdata <= next_rdata;
    end
  end

  // outputs taken straight from flops
  assign boardPowerOn = powerMask;
  // serial lines come straight from the engine flops
  assign adcSclk      = link.sclk;
  assign adcDin       = link.din;

endmodule

// ==== tb/lvp_adc_model.sv ====
// behavioural model of the seven serial converters
`timescale 1ns/10ps
module lvp_adc_model
#(
  parameter int N = 7
)
(
  input  wire logic         sclk,
  input  wire logic         din,
  input  wire logic [N-1:0] csN,
  output logic [N-1:0]      dout
);
  logic [7:0]  ctrl;          // byte shifted in
  logic [15:0] word = 16'h0;  // word shifted out
  int          nf = 0;        // sclk falls this frame
  int          idx;           // selected converter
  wire         idle = &csN;
  // find the selected line
  always_comb
  begin
    idx = 0;
    for (int i = 0; i < N; i++)
      if (!csN[i])
        idx = i;
  end
  // control byte, msb first, on rising sclk
  always @(posedge sclk)
    if (!idle && nf < 8)
      ctrl <= {ctrl[6:0], din};
  // result loaded after the eighth fall, shifted on later falls
  always @(negedge sclk or posedge idle)
    if (idle)
      nf <= 0;
    else
    begin
      nf <= nf + 1;
      word <= (nf == 7) ? {ctrl, 5'b10100, idx[2:0]} : {word[14:0], 1'b0};
    end
  // released lines show the inverse of the active bit
  always_comb
    for (int i = 0; i < N; i++)
      dout[i] = (i == idx && !idle) ? word[15] : ~word[15];
endmodule

// ==== tb/lvp_adc_power_control_chk.sv ====
// assertion checker for the converter control block
`timescale 1ns/10ps
module lvp_adc_power_control_chk
#(
  parameter int NUM_CONV = 7,
  parameter int HALF_CYC = 5,
  parameter int CONV_CYC = 1000
)
(
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                cmdStrobe,
  input wire logic                cmdWrite,
  input wire logic [15:0]         cmdCode,
  input wire lvp_pkg::lvp_word_t  cmdWdata,
  input wire logic                cmdAck,
  input wire lvp_pkg::lvp_word_t  cmdRdata,
  input wire logic                adcSclk,
  input wire logic                adcDin,
  input wire logic [NUM_CONV-1:0] adcCs_n,
  input wire logic [NUM_CONV-1:0] adcDout,
  input wire logic [7:0]          boardPowerOn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [2:0] sel;  // shadow of converter select
  wire        wr = cmdStrobe & cmdWrite;
  wire        rd = cmdStrobe & ~cmdWrite;
  // shadow select follows host writes
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      sel <= 3'h0;
    else if (wr && cmdCode == 16'h8020)
      sel <= cmdWdata[2:0];
  // accepted control byte send
  sequence sendReq;
    wr && cmdCode == 16'h8000 && &adcCs_n && sel < NUM_CONV;
  endsequence
  ack_follows_a: assert property (cmdStrobe |=> cmdAck) else $error("ack missing");
  ack_only_a: assert property (!cmdStrobe |=> !cmdAck) else $error("stray ack");
  power_load_a: assert property (wr && cmdCode == 16'h8010 |=> boardPowerOn == $past(cmdWdata[7:0]))
    else $error("power mask");
  power_hold_a: assert property (!(wr && cmdCode == 16'h8010) |=> $stable(boardPowerOn))
    else $error("power moved");
  state_read_a: assert property (rd && cmdCode == 16'h8018 |=> cmdRdata == {8'h00, $past(boardPowerOn)})
    else $error("power state");
  select_read_a: assert property (rd && cmdCode == 16'h8024 |=> cmdRdata == {13'h0, $past(sel)})
    else $error("select readback");
  send_start_a: assert property (sendReq |=> !adcCs_n[$past(sel)] && adcDin == $past(cmdWdata[7]) && !adcSclk)
    else $error("send start");
  cs_single_a: assert property ($onehot0(~adcCs_n)) else $error("two selects");
endmodule
bind lvp_adc_power_control lvp_adc_power_control_chk #(.NUM_CONV(NUM_CONV), .HALF_CYC(HALF_CYC),
  .CONV_CYC(CONV_CYC)) chk_u (.mclk, .rst_n, .cmdStrobe, .cmdWrite, .cmdCode, .cmdWdata, .cmdAck,
  .cmdRdata, .adcSclk, .adcDin, .adcCs_n, .adcDout, .boardPowerOn);

// ==== tb/testbench.sv ====
// self-checking bench for the converter control block
`timescale 1ns/10ps
module testbench;
  import lvp_pkg::*;
  logic        mclk, rst_n, cmdStrobe, cmdWrite, cmdAck, adcSclk, adcDin;
  logic [15:0] cmdCode;
  lvp_word_t   cmdWdata, cmdRdata, rd;
  logic [6:0]  adcCs_n, adcDout;
  logic [7:0]  boardPowerOn, cb;
  logic [7:0]  cbs [7];      // byte sent to each converter
  logic [31:0] seed = 32'h21;
  logic [31:0] r;
  int          miscompares = 0;
  int          nCompared = 0;
  lvp_adc_power_control #(.HALF_CYC(3), .CONV_CYC(10)) dut_u (.mclk, .rst_n, .cmdStrobe, .cmdWrite,
    .cmdCode, .cmdWdata, .cmdAck, .cmdRdata, .adcSclk, .adcDin, .adcCs_n, .adcDout, .boardPowerOn);
  lvp_adc_model model_u (.sclk(adcSclk), .din(adcDin), .csN(adcCs_n), .dout(adcDout));
  // clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // word the model returns for a byte
  function automatic lvp_word_t expWord(logic [7:0] c, logic [2:0] s);
    return {c, 5'b10100, s};
  endfunction
  task automatic chk(string what, lvp_word_t seen, lvp_word_t exp);
    nCompared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one command, ack checked, read data kept in rd
  task automatic cmd(logic wr, logic [15:0] code, lvp_word_t data);
    cmdStrobe <= 1'b1;
    cmdWrite <= wr;
    cmdCode <= code;
    cmdWdata <= data;
    @(posedge mclk);
    cmdStrobe <= 1'b0;
    #1;
    chk("ack", {15'h0, cmdAck}, 16'h1);
    rd = cmdRdata;
    @(posedge mclk);
  endtask
  // bounded wait for the transfer to end
  task automatic waitDone();
    int n = 0;
    while (!(&adcCs_n) && n < 2000)
    begin
      @(posedge mclk);
      n++;
    end
    chk("cs", {9'h0, adcCs_n}, 16'h7f);
    @(posedge mclk);
  endtask
  task automatic stopTest();
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #80000;
    miscompares++;
    stopTest();
  end
  initial
  begin
    rst_n = 1'b0;
    cmdStrobe = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 16'h0;
    cmdWdata = 16'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk("power reset", {8'h0, boardPowerOn}, 16'h0);
    // power masks: corners, then random
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      cb = (i == 0) ? 8'hff : (i == 1) ? 8'h80 : r[7:0];
      cmd(1'b1, 16'h8010, {8'h0, cb});
      chk("power", {8'h0, boardPowerOn}, {8'h0, cb});
      cmd(1'b0, 16'h8018, 16'h0);
      chk("power state", rd, {8'h0, cb});
    end
    cmd(1'b0, 16'h8008, 16'h0);
    chk("unmapped", rd, 16'h0);
    $display("power test done");
    // each converter: select, send, read the result
    for (int s = 0; s < 7; s++)
    begin
      r = rnd();
      cb = {1'b1, r[6:2], s[1:0]};
      cbs[s] = cb;
      cmd(1'b1, 16'h8020, 16'(s));
      cmd(1'b0, 16'h8024, 16'h0);
      chk("select", rd, 16'(s));
      cmd(1'b1, 16'h8000, {8'h0, cb});
      if (s == 3)
        cmd(1'b1, 16'h8000, 16'h0011);
      waitDone();
      cmd(1'b0, 16'h8004, 16'h0);
      chk("result", rd, expWord(cb, s[2:0]));
    end
    cmd(1'b1, 16'h8020, 16'h2);
    cmd(1'b0, 16'h8004, 16'h0);
    chk("old result", rd, expWord(cbs[2], 3'h2));
    $display("converter test done");
    stopTest();
  end
endmodule
